// File: rtl/cfi_map.svh
`ifndef CFI_MAP_SVH
`define CFI_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CFI_OFF_TX_FID     12'h008
`define CFI_OFF_RX_FID     12'h00C
`define CFI_OFF_INTERRUPT_CONTROL_STATUS       12'h010
`define CFI_OFF_DATA_NB    12'h020
`define CFI_OFF_DATA_BLK   12'h030

// ----------------------------------------------------------------------------
// Feature register fields
// ----------------------------------------------------------------------------
`define CFI_FID_DEPTH_MSB  19
`define CFI_FID_DEPTH_LSB  16
`define CFI_FID_WORD_BIT   10
`define CFI_FID_HALF_BIT   9
`define CFI_FID_BYTE_BIT   8
`define CFI_FID_LANE_MSB   7
`define CFI_FID_LANE_LSB   4
`define CFI_FID_IRQ_BIT    1
`define CFI_FID_ENG_BIT    0

// ----------------------------------------------------------------------------
// Lane width codes
// ----------------------------------------------------------------------------
`define CFI_LANE_CODE_1B   4'h1
`define CFI_LANE_CODE_2B   4'h2
`define CFI_LANE_CODE_4B   4'h4

// ----------------------------------------------------------------------------
// Interrupt control and status fields and resets
// ----------------------------------------------------------------------------
`define CFI_INTERRUPT_CONTROL_STATUS_RX_PEND   31
`define CFI_INTERRUPT_CONTROL_STATUS_RX_LVL_MSB 19
`define CFI_INTERRUPT_CONTROL_STATUS_RX_LVL_LSB 16
`define CFI_INTERRUPT_CONTROL_STATUS_TX_PEND   15
`define CFI_INTERRUPT_CONTROL_STATUS_TX_LVL_MSB 3
`define CFI_INTERRUPT_CONTROL_STATUS_TX_LVL_LSB 0
`define CFI_RX_LVL_RST     4'h1
`define CFI_TX_LVL_RST     4'h0

`endif

// File: rtl/cfi_pkg.sv
package cfi_pkg;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [11:0] addr;
		logic [3:0]  strb;
		logic [31:0] wdata;
	} cfi_req_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] rdata;
	} cfi_rsp_t;

	typedef struct packed {
		logic [7:0] fill;
		logic       full;
		logic       flag_evt;
	} cfi_rx_stat_t;

	typedef struct packed {
		logic [7:0] remaining;
	} cfi_tx_stat_t;

	typedef struct packed {
		logic        valid;
		logic        blocking;
		logic [3:0]  lanes;
		logic [31:0] data;
	} cfi_tx_push_t;

endpackage

// File: rtl/cfi_irq_chan.sv
`timescale 1ns/1ps

module cfi_irq_chan
	import cfi_pkg::*;
#(
	parameter bit         PRESENT = 1'b1,
	parameter logic [3:0] LVL_RST = 4'h0
)(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	// Software side
	input  wire logic       clr,
	input  wire logic       lvl_wr,
	input  wire logic [3:0] lvl_wdata,
	// Engine side
	input  wire logic       evt,
	input  wire logic       enable,
	// State
	output logic            pend_q,
	output logic [3:0]      lvl_q,
	output logic            irq_q
);

	logic       pend_d;
	logic [3:0] lvl_d;
	logic       irq_d;

	// A new event in the clearing cycle wins, so no event is lost.
	assign pend_d = PRESENT & (evt | (pend_q & ~clr));
	assign lvl_d  = !PRESENT ? 4'h0 : (lvl_wr ? lvl_wdata : lvl_q);
	assign irq_d  = PRESENT & enable & pend_q & (lvl_q != 4'h0);

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pend_q <= 1'b0;
			lvl_q  <= PRESENT ? LVL_RST : 4'h0;
			irq_q  <= 1'b0;
		end
		else
		begin
			pend_q <= pend_d;
			lvl_q  <= lvl_d;
			irq_q  <= irq_d;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	set_wins_clr_a: assert property (evt && clr && PRESENT |=> pend_q)
		else $error("Event in clearing cycle was lost.");
	absent_quiet_a: assert property (!PRESENT |-> !pend_q && lvl_q == 4'h0 && !irq_q)
		else $error("Absent interrupt channel shows state.");

endmodule

// File: rtl/cfi_regs.sv
`timescale 1ns/1ps
`include "cfi_map.svh"

module cfi_regs
	import cfi_pkg::*;
#(
	parameter bit         RX_PRESENT    = 1'b1,
	parameter bit         RX_IRQ        = 1'b1,
	parameter logic [3:0] RX_DEPTH_LOG2 = 4'h4,
	parameter logic [2:0] RX_SIZES      = 3'b111,
	parameter bit         TX_PRESENT    = 1'b1,
	parameter bit         TX_IRQ        = 1'b1,
	parameter logic [3:0] TX_DEPTH_LOG2 = 4'h4,
	parameter logic [2:0] TX_SIZES      = 3'b111,
	parameter int         TX_LANE_BYTES = 4
)(
	// Clock and reset
	input  wire logic          core_clk,
	input  wire logic          rst_b,
	// Register access port
	input  wire cfi_req_t      req,
	output cfi_rsp_t           rsp_q,
	// Engine status
	input  wire logic          port_enabled,
	input  wire cfi_rx_stat_t  rx_stat,
	input  wire cfi_tx_stat_t  tx_stat,
	// Transmit data hand-off
	output cfi_tx_push_t       tx_push_q,
	// Interrupt outputs
	output logic               rx_irq_q,
	output logic               tx_irq_q
);

	// ------------------------------------------------------------------------
	// Configuration constants
	// ------------------------------------------------------------------------
	localparam bit RX_IRQ_BUILT = RX_PRESENT & RX_IRQ;
	localparam bit TX_IRQ_BUILT = TX_PRESENT & TX_IRQ;

	// Any unsupported width falls back to the four-byte code, never a reserved one.
	function automatic logic [3:0] lane_code(input int bytes);
		logic [3:0] code;
		code = `CFI_LANE_CODE_4B;
		if (bytes == 1)
			code = `CFI_LANE_CODE_1B;
		else if (bytes == 2)
			code = `CFI_LANE_CODE_2B;
		return code;
	endfunction

	function automatic logic [3:0] lane_mask(input int bytes);
		logic [3:0] mask;
		mask = 4'hF;
		if (bytes == 1)
			mask = 4'h1;
		else if (bytes == 2)
			mask = 4'h3;
		return mask;
	endfunction

	localparam logic [3:0] TX_LANE_CODE = lane_code(TX_LANE_BYTES);
	localparam logic [3:0] TX_LANE_MASK = lane_mask(TX_LANE_BYTES);

	// ------------------------------------------------------------------------
	// Feature identification words
	// ------------------------------------------------------------------------
	logic [31:0] rx_fid_w;
	logic [31:0] tx_fid_w;

	assign rx_fid_w = !RX_PRESENT ? 32'h0000_0000 :
		{12'h000, RX_DEPTH_LOG2, 5'h00, RX_SIZES, 6'h00, RX_IRQ, 1'b1};

	assign tx_fid_w = !TX_PRESENT ? 32'h0000_0000 :
		{12'h000, TX_DEPTH_LOG2, 5'h00, TX_SIZES, TX_LANE_CODE, 2'h0,
		 TX_IRQ, 1'b1};

	// ------------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------------
	logic hit_tx_fid;
	logic hit_rx_fid;
	logic hit_interrupt_control_status;
	logic hit_data;
	logic wr_interrupt_control_status;
	logic wr_data;

	assign hit_tx_fid = req.addr == `CFI_OFF_TX_FID;
	assign hit_rx_fid = req.addr == `CFI_OFF_RX_FID;
	assign hit_interrupt_control_status   = req.addr == `CFI_OFF_INTERRUPT_CONTROL_STATUS;
	assign hit_data   = (req.addr == `CFI_OFF_DATA_NB) || (req.addr == `CFI_OFF_DATA_BLK);
	assign wr_interrupt_control_status    = req.valid && req.write && hit_interrupt_control_status && (RX_IRQ_BUILT || TX_IRQ_BUILT);
	assign wr_data    = req.valid && req.write && hit_data;

	// ------------------------------------------------------------------------
	// Interrupt channels
	// ------------------------------------------------------------------------
	logic       rx_pend;
	logic [3:0] rx_lvl;
	logic       rx_irq_w;
	logic       rx_evt;
	logic       tx_pend;
	logic [3:0] tx_lvl;
	logic       tx_irq_w;
	logic       tx_evt;
	logic       rx_clr;
	logic       tx_clr;
	logic       rx_lvl_wr;
	logic       tx_lvl_wr;

	assign rx_clr    = wr_interrupt_control_status && req.strb[3] && req.wdata[`CFI_INTERRUPT_CONTROL_STATUS_RX_PEND];
	assign tx_clr    = wr_interrupt_control_status && req.strb[1] && req.wdata[`CFI_INTERRUPT_CONTROL_STATUS_TX_PEND];
	assign rx_lvl_wr = wr_interrupt_control_status && req.strb[2];
	assign tx_lvl_wr = wr_interrupt_control_status && req.strb[0];

	// A zero level switches the event source off entirely.
	assign rx_evt = (rx_lvl != 4'h0) &&
		((rx_stat.fill >= {4'h0, rx_lvl}) || rx_stat.full || rx_stat.flag_evt);
	assign tx_evt = (tx_lvl != 4'h0) && (tx_stat.remaining < {4'h0, tx_lvl});

	cfi_irq_chan #(
		.PRESENT   (RX_IRQ_BUILT),
		.LVL_RST   (`CFI_RX_LVL_RST)
	) u_rx_chan (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.clr       (rx_clr),
		.lvl_wr    (rx_lvl_wr),
		.lvl_wdata (req.wdata[`CFI_INTERRUPT_CONTROL_STATUS_RX_LVL_MSB:`CFI_INTERRUPT_CONTROL_STATUS_RX_LVL_LSB]),
		.evt       (rx_evt),
		.enable    (port_enabled),
		.pend_q    (rx_pend),
		.lvl_q     (rx_lvl),
		.irq_q     (rx_irq_w)
	);

	cfi_irq_chan #(
		.PRESENT   (TX_IRQ_BUILT),
		.LVL_RST   (`CFI_TX_LVL_RST)
	) u_tx_chan (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.clr       (tx_clr),
		.lvl_wr    (tx_lvl_wr),
		.lvl_wdata (req.wdata[`CFI_INTERRUPT_CONTROL_STATUS_TX_LVL_MSB:`CFI_INTERRUPT_CONTROL_STATUS_TX_LVL_LSB]),
		.evt       (tx_evt),
		.enable    (port_enabled),
		.pend_q    (tx_pend),
		.lvl_q     (tx_lvl),
		.irq_q     (tx_irq_w)
	);

	// The channel outputs are already registered and gated by the port enable.
	assign rx_irq_q = rx_irq_w;
	assign tx_irq_q = tx_irq_w;

	// ------------------------------------------------------------------------
	// Interrupt control word
	// ------------------------------------------------------------------------
	logic [31:0] interrupt_control_status_w;

	assign interrupt_control_status_w = {rx_pend, 11'h000, rx_lvl, tx_pend, 11'h000, tx_lvl};

	// ------------------------------------------------------------------------
	// Read response
	// ------------------------------------------------------------------------
	logic [31:0] rdata_d;
	cfi_rsp_t    rsp_d;

	// Data port reads return zero here; the receive datapath answers them elsewhere.
	assign rdata_d = hit_tx_fid ? tx_fid_w :
	                 hit_rx_fid ? rx_fid_w :
	                 hit_interrupt_control_status   ? interrupt_control_status_w   : 32'h0000_0000;
	assign rsp_d.valid = req.valid;
	assign rsp_d.rdata = (req.valid && !req.write) ? rdata_d : 32'h0000_0000;

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			rsp_q <= '0;
		else
			rsp_q <= rsp_d;
	end

	// ------------------------------------------------------------------------
	// Transmit data hand-off
	// ------------------------------------------------------------------------
	cfi_tx_push_t push_d;
	logic [31:0]  push_data;
	logic [3:0]   push_lanes;

	// Lanes above the engine width are dropped, so a careless writer cannot overrun it.
	assign push_lanes = req.strb & TX_LANE_MASK;
	assign push_data  = req.wdata & {{8{push_lanes[3]}}, {8{push_lanes[2]}},
	                                 {8{push_lanes[1]}}, {8{push_lanes[0]}}};
	assign push_d.valid    = wr_data && TX_PRESENT && port_enabled &&
	                         (push_lanes != 4'h0);
	assign push_d.blocking = push_d.valid && (req.addr == `CFI_OFF_DATA_BLK);
	assign push_d.lanes    = push_d.valid ? push_lanes : 4'h0;
	assign push_d.data     = push_d.valid ? push_data : 32'h0000_0000;

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			tx_push_q <= '0;
		else
			tx_push_q <= push_d;
	end

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	rx_irq_gate_a: assert property (!port_enabled |=> !rx_irq_q)
		else $error("Receive interrupt raised while port disabled.");

	tx_irq_gate_a: assert property (!port_enabled |=> !tx_irq_q)
		else $error("Transmit interrupt raised while port disabled.");

	rx_event_set_a: assert property (RX_IRQ_BUILT && rx_evt |=> rx_pend)
		else $error("Receive event did not set pending bit.");

	rx_w1c_a: assert property (rx_clr && !rx_evt |=> !rx_pend ##1 !rx_irq_q)
		else $error("Receive pending bit or output did not clear.");

	tx_event_set_a: assert property (TX_IRQ_BUILT && tx_evt |=> tx_pend)
		else $error("Transmit event did not set pending bit.");

	tx_w1c_a: assert property (tx_clr && !tx_evt |=> !tx_pend ##1 !tx_irq_q)
		else $error("Transmit pending bit or output did not clear.");

	rx_lvl_write_a: assert property (RX_IRQ_BUILT && rx_lvl_wr |=>
		rx_lvl == $past(req.wdata[19:16]))
		else $error("Receive level write not stored.");

	tx_lvl_write_a: assert property (TX_IRQ_BUILT && tx_lvl_wr |=>
		tx_lvl == $past(req.wdata[3:0]))
		else $error("Transmit level write not stored.");

	irq_follows_a: assert property (port_enabled && rx_pend && rx_lvl != 4'h0 |=> rx_irq_q)
		else $error("Receive interrupt not raised for pending bit.");

	rx_fid_read_a: assert property (req.valid && !req.write && hit_rx_fid |=>
		rsp_q.valid && rsp_q.rdata == $past(rx_fid_w))
		else $error("Receive feature read returned wrong word.");

	tx_fid_read_a: assert property (req.valid && !req.write && hit_tx_fid |=>
		rsp_q.rdata[7:4] inside {4'h1, 4'h2, 4'h4} || !TX_PRESENT)
		else $error("Reserved lane width code reported.");

	interrupt_control_status_absent_a: assert property (!RX_IRQ_BUILT && !TX_IRQ_BUILT && req.valid &&
		!req.write && hit_interrupt_control_status |=> rsp_q.rdata == 32'h0000_0000)
		else $error("Absent interrupt register read nonzero.");

	lane_drop_a: assert property (tx_push_q.valid |->
		(tx_push_q.lanes & ~TX_LANE_MASK) == 4'h0)
		else $error("Byte above lane width passed to engine.");

	push_take_a: assert property (req.valid && req.write && req.addr == `CFI_OFF_DATA_NB &&
		req.strb[0] && port_enabled && TX_PRESENT |=> tx_push_q.valid && !tx_push_q.blocking)
		else $error("Data write was not handed to the transmit engine.");

	tx_irq_follows_a: assert property (port_enabled && tx_pend && tx_lvl != 4'h0 |=> tx_irq_q)
		else $error("Transmit interrupt not raised for pending bit.");

	rx_irq_drop_a: assert property (!rx_pend |=> !rx_irq_q)
		else $error("Receive interrupt high without pending bit.");

	tx_irq_drop_a: assert property (!tx_pend |=> !tx_irq_q)
		else $error("Transmit interrupt high without pending bit.");

	rx_irq_seen_c: cover property (rx_evt ##1 rx_pend ##1 rx_irq_q);
	tx_irq_seen_c: cover property (tx_evt ##1 tx_pend ##1 tx_irq_q);
	clear_race_c:  cover property (rx_clr && rx_evt);
	push_seen_c:   cover property (tx_push_q.valid && tx_push_q.lanes != 4'hF);

endmodule

// File: sim/cfi_host_model.sv
`timescale 1ns/1ps

module cfi_host_model
	import cfi_pkg::*;
(
	// Clock
	input  wire logic     core_clk,
	// Register access port
	output cfi_req_t      req,
	input  wire cfi_rsp_t rsp_q
);

	initial req = '0;

	// ------------------------------------------------------------------
	// Access
	// ------------------------------------------------------------------
	// The strobe lasts one cycle; released fields show inverted values so that
	// a design which samples them late cannot pass by luck.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] rd, output bit ok);
		ok = 1'b0;
		rd = '0;
		@(posedge core_clk);
		#1;
		req = '{valid: 1'b1, write: w, addr: a, strb: s, wdata: d};
		@(posedge core_clk);
		#1;
		req = '{valid: 1'b0, write: ~w, addr: ~a, strb: ~s, wdata: ~d};
		for (int i = 0; i < 3 && !ok; i++)
		begin
			if (rsp_q.valid === 1'b1)
			begin
				rd = rsp_q.rdata;
				ok = 1'b1;
			end
			else
			begin
				@(posedge core_clk);
				#1;
			end
		end
	endtask

endmodule

// File: sim/test_cfi_regs.sv
`timescale 1ns/1ps

module test_cfi_regs
	import cfi_pkg::*;
;

	logic         core_clk;
	logic         rst_b;
	cfi_req_t     req;
	cfi_rsp_t     rsp_q;
	logic         port_enabled;
	cfi_rx_stat_t rx_stat;
	cfi_tx_stat_t tx_stat;
	cfi_tx_push_t tx_push_q;
	logic         rx_irq_q;
	logic         tx_irq_q;
	cfi_rsp_t     bare_rsp;
	cfi_tx_push_t bare_push;
	logic         bare_rx_irq;
	logic         bare_tx_irq;
	int           err_total;
	int           checked;
	logic [31:0]  seed;
	logic [31:0]  rd;
	logic [3:0]   ln;
	logic [31:0]  m;

	// A two-byte engine makes the lane drop visible on data writes.
	cfi_regs #(.TX_LANE_BYTES(2)) u_dut (
		.core_clk     (core_clk),
		.rst_b        (rst_b),
		.req          (req),
		.rsp_q        (rsp_q),
		.port_enabled (port_enabled),
		.rx_stat      (rx_stat),
		.tx_stat      (tx_stat),
		.tx_push_q    (tx_push_q),
		.rx_irq_q     (rx_irq_q),
		.tx_irq_q     (tx_irq_q)
	);

	// Nothing built here, so every feature word and the interrupt register must read zero.
	cfi_regs #(.RX_PRESENT(1'b0), .TX_PRESENT(1'b0)) u_bare (
		.core_clk     (core_clk),
		.rst_b        (rst_b),
		.req          (req),
		.rsp_q        (bare_rsp),
		.port_enabled (port_enabled),
		.rx_stat      (rx_stat),
		.tx_stat      (tx_stat),
		.tx_push_q    (bare_push),
		.rx_irq_q     (bare_rx_irq),
		.tx_irq_q     (bare_tx_irq)
	);

	cfi_host_model u_host (
		.core_clk (core_clk),
		.req      (req),
		.rsp_q    (rsp_q)
	);

	always #12.5 core_clk = ~core_clk;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [31:0] feat_exp(input logic [3:0] dp, input logic [2:0] sz,
		input logic [3:0] lane, input logic irq, input logic eng);
		return {12'h000, dp, 5'h00, sz, lane, 2'h0, irq, eng};
	endfunction

	function automatic logic [31:0] interrupt_control_status_exp(input logic rp, input logic [3:0] rl,
		input logic tp, input logic [3:0] tl);
		return {rp, 11'h000, rl, tp, 11'h000, tl};
	endfunction

	task automatic summarize();
		$display("mismatches %0d of %0d comparisons", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask

	task automatic bus(input logic w, input logic [11:0] a, input logic [3:0] s,
		input logic [31:0] d);
		bit ok;
		u_host.xfer(w, a, s, d, rd, ok);
		chk("answer", {31'h0, ok}, 32'h1);
		if (!ok)
			summarize();
	endtask

	task automatic wait_irq(input bit rx, input logic e);
		logic v;
		v = rx ? rx_irq_q : tx_irq_q;
		for (int i = 0; i < 6 && v !== e; i++)
		begin
			tick();
			v = rx ? rx_irq_q : tx_irq_q;
		end
		chk("irq level", {31'h0, v}, {31'h0, e});
		if (v !== e)
			summarize();
	endtask

	// ------------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------------
	initial
	begin
		core_clk = 1'b0;
		rst_b = 1'b0;
		port_enabled = 1'b1;
		rx_stat = '0;
		tx_stat = '{remaining: 8'hFF};
		seed = 32'h4b99_099d;
		err_total = 0;
		checked = 0;
		repeat (6) @(posedge core_clk);
		#1;
		rst_b = 1'b1;
		bus(1'b1, 12'h008, 4'hF, 32'hFFFF_FFFF);
		bus(1'b0, 12'h008, 4'h0, 32'h0);
		chk("tx feature", rd, feat_exp(4'h4, 3'b111, 4'h2, 1'b1, 1'b1));
		chk("bare answer", {31'h0, bare_rsp.valid}, 32'h1);
		chk("bare tx feature", bare_rsp.rdata, 32'h0);
		bus(1'b0, 12'h00C, 4'h0, 32'h0);
		chk("rx feature", rd, feat_exp(4'h4, 3'b111, 4'h0, 1'b1, 1'b1));
		chk("bare rx feature", bare_rsp.rdata, 32'h0);
		bus(1'b0, 12'h010, 4'h0, 32'h0);
		chk("interrupt_control_status reset", rd, interrupt_control_status_exp(1'b0, 4'h1, 1'b0, 4'h0));
		chk("bare interrupt_control_status", bare_rsp.rdata, 32'h0);
		bus(1'b0, 12'h004, 4'h0, 32'h0);
		chk("unmapped", rd, 32'h0);
		// Levels only; no event can fire with an empty receive side and a full window.
		for (int i = 0; i < 8; i++)
		begin
			seed = lfsr(seed);
			bus(1'b1, 12'h010, 4'b0101, seed);
			bus(1'b0, 12'h010, 4'h0, 32'h0);
			chk("interrupt_control_status levels", rd, interrupt_control_status_exp(1'b0, seed[19:16], 1'b0, seed[3:0]));
			chk("bare interrupt_control_status levels", bare_rsp.rdata, 32'h0);
		end
		bus(1'b1, 12'h010, 4'hF, 32'h0003_0000);
		for (int c = 0; c < 3; c++)
		begin
			tick();
			rx_stat = '{fill: (c == 0) ? 8'd3 : 8'd0, full: c == 1, flag_evt: c == 2};
			tick();
			rx_stat = '0;
			wait_irq(1'b1, 1'b1);
			chk("bare irq", {30'h0, bare_rx_irq, bare_tx_irq}, 32'h0);
			bus(1'b1, 12'h010, 4'h8, 32'h8000_0000);
			wait_irq(1'b1, 1'b0);
		end
		rx_stat.fill = 8'd2;
		repeat (3) tick();
		bus(1'b0, 12'h010, 4'h0, 32'h0);
		chk("below level", rd, interrupt_control_status_exp(1'b0, 4'h3, 1'b0, 4'h0));
		rx_stat = '0;
		port_enabled = 1'b0;
		rx_stat.full = 1'b1;
		tick();
		rx_stat.full = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			tick();
			chk("irq while off", {31'h0, rx_irq_q}, 32'h0);
		end
		bus(1'b1, 12'h020, 4'hF, 32'h1234_5678);
		chk("push while off", {31'h0, tx_push_q.valid}, 32'h0);
		bus(1'b0, 12'h010, 4'h0, 32'h0);
		chk("pend while off", rd, interrupt_control_status_exp(1'b1, 4'h3, 1'b0, 4'h0));
		port_enabled = 1'b1;
		wait_irq(1'b1, 1'b1);
		bus(1'b1, 12'h010, 4'hF, 32'h8000_0003);
		wait_irq(1'b1, 1'b0);
		tx_stat.remaining = 8'd3;
		repeat (3) tick();
		chk("tx at level", {31'h0, tx_irq_q}, 32'h0);
		tx_stat.remaining = 8'd2;
		wait_irq(1'b0, 1'b1);
		tx_stat.remaining = 8'hFF;
		bus(1'b1, 12'h010, 4'h2, 32'h0000_8000);
		wait_irq(1'b0, 1'b0);
		bus(1'b1, 12'h010, 4'hF, 32'h0000_0000);
		tx_stat.remaining = 8'h00;
		rx_stat.full = 1'b1;
		repeat (3) tick();
		bus(1'b0, 12'h010, 4'h0, 32'h0);
		chk("levels zero", rd, 32'h0);
		tx_stat.remaining = 8'hFF;
		rx_stat.full = 1'b0;
		// The first write is the narrow form a two-byte engine expects.
		for (int i = 0; i < 10; i++)
		begin
			seed = lfsr(seed);
			if (i == 0)
				seed[3:0] = 4'b0011;
			if (i == 1)
				seed[3:0] = 4'b1100;
			ln = seed[3:0] & 4'b0011;
			m = {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
			bus(1'b1, seed[4] ? 12'h030 : 12'h020, seed[3:0], seed ^ 32'hA5A5_0000);
			chk("push ctl", {tx_push_q.valid, tx_push_q.blocking, tx_push_q.lanes},
				(ln != 4'h0) ? {1'b1, seed[4], ln} : 6'h00);
			chk("push data", tx_push_q.data, (seed ^ 32'hA5A5_0000) & m);
			chk("bare push", {31'h0, bare_push.valid}, 32'h0);
		end
		summarize();
	end

endmodule
